// >>> design/omr_pkg.sv
// Constants, command encodings and carriers for the output mode and range
// controller. Assumes a 10 MHz core clock and an APB register port.
package omr_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_US = 10_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TRAN_MAX_S = 10;
  localparam logic [15:0] TRAN_MAX_TICKS =
    16'(TRAN_MAX_S * 1_000_000 / TICK_US);

  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERR = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_TRIG = 8'h10;
  localparam logic [7:0] ADDR_QRES = 8'h14;
  localparam logic [7:0] ADDR_DUR = 8'h18;
  localparam int unsigned ERR_CLR_BIT = 16;

  localparam logic signed [15:0] V_MAX = 16'sh6400;
  localparam logic signed [15:0] I_MAX = 16'sh4000;
  localparam logic signed [15:0] ERR_RANGE = -16'sd222;
  localparam logic signed [15:0] ERR_CMD = -16'sd100;
  localparam logic signed [15:0] ERR_WARN = -16'sd300;
  localparam logic [15:0] RANGE_FULL = 16'h0001;
  localparam logic [15:0] RANGE_QUARTER = 16'h0004;
  localparam logic [2:0] RCODE_FULL = 3'h1;
  localparam logic [2:0] RCODE_QUARTER = 3'h4;
  localparam logic QTY_VOLT = 1'b0;
  localparam logic QTY_CURR = 1'b1;

  typedef enum logic [3:0] {
    OMR_OP_NOP, OMR_OP_LEVEL, OMR_OP_TRIG_LEVEL, OMR_OP_MODE_FIX,
    OMR_OP_MODE_LIST, OMR_OP_MODE_TRAN, OMR_OP_TRIGGER, OMR_OP_RANGE,
    OMR_OP_CURR_RANGE, OMR_OP_AUTO, OMR_OP_FUNC, OMR_OP_RESET,
    OMR_OP_LIST_EDIT, OMR_OP_QMAX, OMR_OP_QMIN
  } omr_op_e;

  typedef enum {OMR_FIXED, OMR_LIST, OMR_TRAN} omr_mode_e;

  typedef struct packed {
    logic [15:0] value;
    logic [10:0] rsvd;
    logic qty;
    logic [3:0] op;
  } omr_cmd_s;

  typedef struct packed {
    logic valid;
    logic signed [15:0] code;
  } omr_err_s;

endpackage

// >>> design/omr_ctrl.sv
// Output level mode and range controller, driven by commands written over
// APB. Assumes list storage sits outside and feeds step levels on the same
// clock; list_done and step_valid are single-cycle pulses.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module omr_ctrl #(
  parameter int unsigned TICK_CYCLES = omr_pkg::TICK_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_list_step_valid,
  input wire logic signed [15:0] i_list_level,
  input wire logic i_list_done,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic signed [15:0] o_volt_level,
  output logic signed [15:0] o_curr_level,
  output logic o_volt_quarter,
  output logic o_curr_quarter,
  output logic o_curr_mode,
  output logic o_list_start,
  output logic o_list_abort,
  output logic o_list_qty,
  output logic o_list_edit
);

  logic signed [15:0] lvl [2];
  logic signed [15:0] trig [2];
  logic signed [15:0] snap [2];
  logic signed [15:0] saved [2];
  omr_pkg::omr_mode_e mode [2];
  logic quarter [2];
  logic autoscale [2];
  logic func_curr;
  logic list_qty;
  logic pulse_active;
  logic [15:0] pulse_duration;
  logic [15:0] pulse_left;
  logic [31:0] tick_cnt;
  logic tick;
  logic signed [15:0] qres;
  omr_pkg::omr_err_s err;
  logic cmd_go;
  logic err_clr;
  omr_pkg::omr_cmd_s cmd;
  logic signed [15:0] val;
  logic ok;
  logic err_evt;
  logic signed [15:0] err_code;
  logic fire;
  logic pulse_done;
  logic any_list;

  function automatic logic signed [15:0] qmax(input logic q);
    qmax = q ? omr_pkg::I_MAX : omr_pkg::V_MAX;
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // True when a value fits inside one quarter of nominal full scale.
  function automatic logic fits_quarter(input logic q,
                                        input logic signed [15:0] v);
    fits_quarter = mag(v) <= (16'(qmax(q)) >> 2);
  endfunction

  function automatic logic [2:0] rcode(input logic qr);
    rcode = qr ? omr_pkg::RCODE_QUARTER : omr_pkg::RCODE_FULL;
  endfunction

  function automatic logic [1:0] mcode(input omr_pkg::omr_mode_e m);
    mcode = 2'(m);
  endfunction

  assign cmd = omr_pkg::omr_cmd_s'(i_pwdata);
  assign val = cmd.value;
  assign cmd_go = i_psel && i_penable && o_pready && i_pwrite &&
                  (i_paddr == omr_pkg::ADDR_CMD);
  assign err_clr = i_psel && i_penable && o_pready && i_pwrite &&
                   (i_paddr == omr_pkg::ADDR_ERR) &&
                   i_pwdata[omr_pkg::ERR_CLR_BIT];
  assign any_list = (mode[0] == omr_pkg::OMR_LIST) ||
                    (mode[1] == omr_pkg::OMR_LIST);
  assign pulse_done = pulse_active && (pulse_left == 16'h0000);

  // Command checking: decides whether a command applies and what it posts.
  always_comb
  begin
    ok = cmd_go;
    err_evt = 1'b0;
    err_code = omr_pkg::ERR_CMD;
    fire = 1'b0;
    if (cmd_go)
    begin
      case (omr_pkg::omr_op_e'(cmd.op))
        omr_pkg::OMR_OP_LEVEL, omr_pkg::OMR_OP_TRIG_LEVEL:
        begin
          if (val > qmax(cmd.qty) || val < -qmax(cmd.qty))
          begin
            ok = 1'b0;
            err_evt = 1'b1;
            err_code = omr_pkg::ERR_RANGE;
          end
          else if (cmd.op == omr_pkg::OMR_OP_LEVEL && quarter[cmd.qty] &&
                   !autoscale[cmd.qty] && !fits_quarter(cmd.qty, val))
          begin
            ok = 1'b0;
            err_evt = 1'b1;
            err_code = omr_pkg::ERR_RANGE;
          end
          else if (cmd.op == omr_pkg::OMR_OP_LEVEL)
            fire = mode[cmd.qty] == omr_pkg::OMR_TRAN;
        end
        omr_pkg::OMR_OP_MODE_TRAN:
          if (cmd.value > omr_pkg::TRAN_MAX_TICKS)
          begin
            ok = 1'b0;
            err_evt = 1'b1;
            err_code = omr_pkg::ERR_RANGE;
          end
        omr_pkg::OMR_OP_TRIGGER:
          fire = (mode[0] == omr_pkg::OMR_TRAN) ||
                 (mode[1] == omr_pkg::OMR_TRAN);
        omr_pkg::OMR_OP_RANGE, omr_pkg::OMR_OP_CURR_RANGE:
        begin
          if (cmd.value != omr_pkg::RANGE_FULL &&
              cmd.value != omr_pkg::RANGE_QUARTER)
          begin
            ok = 1'b0;
            err_evt = 1'b1;
            err_code = omr_pkg::ERR_RANGE;
          end
          else if (cmd.op == omr_pkg::OMR_OP_CURR_RANGE && !func_curr)
          begin
            err_evt = 1'b1;
            err_code = omr_pkg::ERR_WARN;
          end
        end
        omr_pkg::OMR_OP_LIST_EDIT:
          if (any_list)
          begin
            ok = 1'b0;
            err_evt = 1'b1;
            err_code = omr_pkg::ERR_CMD;
          end
        omr_pkg::OMR_OP_NOP, omr_pkg::OMR_OP_MODE_FIX,
        omr_pkg::OMR_OP_MODE_LIST, omr_pkg::OMR_OP_AUTO,
        omr_pkg::OMR_OP_FUNC, omr_pkg::OMR_OP_RESET,
        omr_pkg::OMR_OP_QMAX, omr_pkg::OMR_OP_QMIN:
          ok = 1'b1;
        default:
        begin
          ok = 1'b0;
          err_evt = 1'b1;
          err_code = omr_pkg::ERR_CMD;
        end
      endcase
    end
  end

  // Hundredth-second tick, restarted on each fire so pulses are exact.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (fire || tick_cnt >= TICK_CYCLES - 1)
    begin
      tick_cnt <= 32'h0000_0000;
      tick <= !fire;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pulse_left <= 16'h0000;
    else if (fire)
      pulse_left <= pulse_duration;
    else if (tick && pulse_left != 16'h0000)
      pulse_left <= pulse_left - 16'h0001;
  end

  // Error holder: a new event wins over a clear in the same cycle.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      err <= '0;
    else if (err_evt)
      err <= '{valid: 1'b1, code: err_code};
    else if (err_clr)
      err.valid <= 1'b0;
  end

  // Level, mode and range state.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int q = 0; q < 2; q++)
      begin
        lvl[q] <= 16'sh0000;
        trig[q] <= 16'sh0000;
        snap[q] <= 16'sh0000;
        saved[q] <= 16'sh0000;
        mode[q] <= omr_pkg::OMR_FIXED;
        quarter[q] <= 1'b1;
        autoscale[q] <= 1'b1;
      end
      func_curr <= 1'b0;
      list_qty <= 1'b0;
      pulse_active <= 1'b0;
      pulse_duration <= 16'h0000;
      qres <= 16'sh0000;
      o_list_start <= 1'b0;
      o_list_abort <= 1'b0;
      o_list_edit <= 1'b0;
    end
    else
    begin
      o_list_start <= 1'b0;
      o_list_abort <= 1'b0;
      o_list_edit <= 1'b0;
      if (pulse_done)
      begin
        pulse_active <= 1'b0;
        for (int q = 0; q < 2; q++)
        begin
          lvl[q] <= saved[q];
          if (autoscale[q])
            quarter[q] <= fits_quarter(q[0], saved[q]);
        end
      end
      if (mode[list_qty] == omr_pkg::OMR_LIST)
      begin
        if (i_list_step_valid)
        begin
          lvl[list_qty] <= i_list_level;
          if (autoscale[list_qty])
            quarter[list_qty] <= fits_quarter(list_qty, i_list_level);
        end
        if (i_list_done)
          mode[list_qty] <= omr_pkg::OMR_FIXED;
      end
      if (ok)
      begin
        case (omr_pkg::omr_op_e'(cmd.op))
          omr_pkg::OMR_OP_LEVEL:
          begin
            if (fire)
            begin
              saved <= lvl;
              pulse_active <= 1'b1;
              mode[cmd.qty] <= omr_pkg::OMR_FIXED;
            end
            lvl[cmd.qty] <= val;
            if (autoscale[cmd.qty])
              quarter[cmd.qty] <= fits_quarter(cmd.qty, val);
          end
          omr_pkg::OMR_OP_TRIG_LEVEL:
            trig[cmd.qty] <= val;
          omr_pkg::OMR_OP_TRIGGER:
          begin
            if (fire)
            begin
              saved <= lvl;
              pulse_active <= 1'b1;
            end
            for (int q = 0; q < 2; q++)
            begin
              lvl[q] <= trig[q];
              if (autoscale[q])
                quarter[q] <= fits_quarter(q[0], trig[q]);
              if (mode[q] == omr_pkg::OMR_TRAN)
                mode[q] <= omr_pkg::OMR_FIXED;
            end
          end
          omr_pkg::OMR_OP_MODE_FIX:
          begin
            if (mode[cmd.qty] == omr_pkg::OMR_LIST)
            begin
              lvl <= snap;
              o_list_abort <= 1'b1;
            end
            mode[cmd.qty] <= omr_pkg::OMR_FIXED;
          end
          omr_pkg::OMR_OP_MODE_LIST:
            if (!any_list)
            begin
              snap <= lvl;
              mode[cmd.qty] <= omr_pkg::OMR_LIST;
              list_qty <= cmd.qty;
              o_list_start <= 1'b1;
            end
          omr_pkg::OMR_OP_MODE_TRAN:
          begin
            mode[cmd.qty] <= omr_pkg::OMR_TRAN;
            pulse_duration <= cmd.value;
          end
          omr_pkg::OMR_OP_RANGE:
          begin
            quarter[func_curr] <= cmd.value == omr_pkg::RANGE_QUARTER;
            autoscale[0] <= 1'b0;
            autoscale[1] <= 1'b0;
          end
          omr_pkg::OMR_OP_CURR_RANGE:
          begin
            quarter[1] <= cmd.value == omr_pkg::RANGE_QUARTER;
            autoscale[0] <= 1'b0;
            autoscale[1] <= 1'b0;
          end
          omr_pkg::OMR_OP_AUTO:
            for (int q = 0; q < 2; q++)
            begin
              autoscale[q] <= cmd.value[0];
              if (cmd.value[0])
                quarter[q] <= fits_quarter(q[0], lvl[q]);
            end
          omr_pkg::OMR_OP_FUNC:
          begin
            func_curr <= cmd.value[0];
            quarter[1] <= autoscale[1] && fits_quarter(1'b1, lvl[1]);
          end
          omr_pkg::OMR_OP_RESET:
          begin
            for (int q = 0; q < 2; q++)
            begin
              lvl[q] <= 16'sh0000;
              mode[q] <= omr_pkg::OMR_FIXED;
              quarter[q] <= 1'b1;
              autoscale[q] <= 1'b1;
            end
            func_curr <= 1'b0;
            pulse_active <= 1'b0;
            o_list_abort <= any_list;
          end
          omr_pkg::OMR_OP_LIST_EDIT:
            o_list_edit <= 1'b1;
          omr_pkg::OMR_OP_QMAX:
            qres <= qmax(cmd.qty);
          omr_pkg::OMR_OP_QMIN:
            qres <= -qmax(cmd.qty);
          default:
            qres <= qres;
        endcase
      end
    end
  end

  assign o_volt_level = lvl[0];
  assign o_curr_level = lvl[1];
  assign o_volt_quarter = quarter[0];
  assign o_curr_quarter = quarter[1];
  assign o_curr_mode = func_curr;
  assign o_list_qty = list_qty;

  // APB slave: one wait-free access phase, read data captured in setup.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end
    else
    begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      if (i_psel && !i_penable)
      begin
        case (i_paddr)
          omr_pkg::ADDR_CMD, omr_pkg::ADDR_DUR:
            o_prdata <= (i_paddr == omr_pkg::ADDR_DUR) ?
                        {16'h0000, pulse_duration} : 32'h0000_0000;
          omr_pkg::ADDR_STATUS:
            o_prdata <= {11'h000, pulse_active, 1'b0,
                         rcode(quarter[func_curr]), 1'b0,
                         rcode(quarter[1]), 1'b0, rcode(quarter[0]), 1'b0,
                         autoscale[1], autoscale[0], func_curr,
                         mcode(mode[1]), mcode(mode[0])};
          omr_pkg::ADDR_ERR:
            o_prdata <= {15'h0000, err.valid, err.code};
          omr_pkg::ADDR_LEVEL:
            o_prdata <= {lvl[1], lvl[0]};
          omr_pkg::ADDR_TRIG:
            o_prdata <= {trig[1], trig[0]};
          omr_pkg::ADDR_QRES:
            o_prdata <= {16'h0000, qres};
          default:
            o_pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// >>> verif/omr_ctrl_checker.sv
// Port checker for the output mode and range controller.
// Bound to every omr_ctrl; sees only its ports, one clock domain.
`timescale 1ns/1ns
module omr_ctrl_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_curr_mode,
  input wire logic o_list_start,
  input wire logic o_list_abort,
  input wire logic o_list_edit
);
  logic cmdw;
  logic [3:0] op;
  assign op = i_pwdata[3:0];
  assign cmdw = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == 8'h00);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  a_ready_needs_sel: assert property (!i_psel |-> !o_pready)
    else $error("pready without select");
  a_slverr_unmapped: assert property (
    o_pready && i_paddr > 8'h18 |-> o_pslverr)
    else $error("unmapped access not refused");
  a_slverr_mapped: assert property (
    o_pready && i_paddr <= 8'h18 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("mapped access refused");
  a_start_cause: assert property (
    o_list_start |-> $past(cmdw && op == 4'h4))
    else $error("list start without list command");
  a_abort_cause: assert property (
    o_list_abort |-> $past(cmdw && (op == 4'h3 || op == 4'hB)))
    else $error("list abort without fixed or reset command");
  a_edit_cause: assert property (
    o_list_edit |-> $past(cmdw && op == 4'hC))
    else $error("list edit without edit command");
  a_func_cause: assert property (
    $changed(o_curr_mode) |-> $past(cmdw && (op == 4'hA || op == 4'hB)))
    else $error("function mode changed by itself");
endmodule
bind omr_ctrl omr_ctrl_checker omr_ctrl_checker_i (.i_core_clk, .i_rst_b,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
  .o_curr_mode, .o_list_start, .o_list_abort, .o_list_edit);

// >>> verif/omr_list_model.sv
// Behavioural list store: three steps, then a done pulse.
// Steps come every i_gap+1 cycles; the level bus is scrambled between steps.
`timescale 1ns/1ns
module omr_list_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_gap,
  input wire logic i_start,
  input wire logic i_abort,
  output logic o_step,
  output logic signed [15:0] o_level,
  output logic o_done
);
  logic run;
  logic [7:0] cnt;
  logic [1:0] k;
  logic hit;
  assign hit = run && (cnt == i_gap);
  assign o_step = hit && (k != 2'h3);
  assign o_done = hit && (k == 2'h3);
  assign o_level = o_step ? {6'h00, k + 2'h1, 8'h00} : {cnt, ~cnt};
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      run <= 1'b0;
      cnt <= 8'h00;
      k <= 2'h0;
    end
    else if (i_abort)
      run <= 1'b0;
    else if (i_start)
    begin
      run <= 1'b1;
      cnt <= 8'h00;
      k <= 2'h0;
    end
    else if (run)
    begin
      cnt <= hit ? 8'h00 : cnt + 8'h01;
      k <= hit ? k + 2'h1 : k;
      run <= !o_done;
    end
  end
endmodule

// >>> verif/output_mode_range_control_tb.sv
// Self-checking bench for omr_ctrl with an APB master and a list store.
// Reads note expectations in a queue; a monitor compares them.
`timescale 1ns/1ns
module output_mode_range_control_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [7:0] gap = 8'h01;
  logic [31:0] prd;
  logic prdy, perr, lstep, ldone, lstart, labort, vq, iq, imode;
  logic lqty, ledit;
  int n_edit = 0;
  logic signed [15:0] llev, vlev, ilev;
  logic [64:0] expq[$];
  logic [64:0] e;
  logic [15:0] rv;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  integer seed = 32'ha4898387;
  omr_ctrl #(.TICK_CYCLES(10)) omr_ctrl_i (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
    .i_pwdata(pwd), .i_list_step_valid(lstep), .i_list_level(llev),
    .i_list_done(ldone), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .o_volt_level(vlev), .o_curr_level(ilev), .o_volt_quarter(vq),
    .o_curr_quarter(iq), .o_curr_mode(imode), .o_list_start(lstart),
    .o_list_abort(labort), .o_list_qty(lqty), .o_list_edit(ledit));
  omr_list_model omr_list_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_gap(gap),
    .i_start(lstart), .i_abort(labort), .o_step(lstep), .o_level(llev),
    .o_done(ldone));
  initial
    forever #50 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (prdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x, input logic err = 1'b0);
    expq.push_back({err, m, x});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input omr_pkg::omr_op_e op, input logic q,
    input logic [15:0] v);
    omr_pkg::omr_cmd_s c;
    c = '{value: v, rsvd: 11'h0, qty: q, op: op};
    xfer(1'b1, omr_pkg::ADDR_CMD, c);
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic err_is(input logic [31:0] x);
    rd(omr_pkg::ADDR_ERR, 32'h0001FFFF, x);
    xfer(1'b1, omr_pkg::ADDR_ERR, 32'h00010000);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (ledit === 1'b1)
      n_edit++;
    if (cyc > 20000)
    begin
      n_fail++;
      give_verdict();
    end
    if (psel && pen && prdy && !pwr)
    begin
      e = expq.pop_front();
      check("read data", prd & e[63:32], e[31:0]);
      check("slave error", 32'(perr), 32'(e[64]));
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("vq", 32'(vq), 32'h1);
    rd(omr_pkg::ADDR_STATUS, 32'h0017777F, 32'h00044460);
    rd(8'h40, 32'h0, 32'h0, 1'b1);
    rv = 16'($unsigned($random(seed)) % 32'h1900) + 16'h0001;
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, rv);
    check("vlev", 32'(vlev), 32'(rv));
    check("vq", 32'(vq), 32'h1);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h1901);
    check("vq", 32'(vq), 32'h0);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h6401);
    check("vlev", 32'(vlev), 32'h1901);
    err_is(32'h0001FF22);
    cmd(omr_pkg::OMR_OP_QMAX, 1'b0, 16'h0);
    rd(omr_pkg::ADDR_QRES, 32'hFFFF, 32'h6400);
    cmd(omr_pkg::OMR_OP_QMIN, 1'b0, 16'h0);
    rd(omr_pkg::ADDR_QRES, 32'hFFFF, 32'h9C00);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h0100);
    cmd(omr_pkg::OMR_OP_RANGE, 1'b0, 16'h1);
    check("vq", 32'(vq), 32'h0);
    rd(omr_pkg::ADDR_STATUS, 32'h00070060, 32'h00010000);
    cmd(omr_pkg::OMR_OP_RANGE, 1'b0, 16'h4);
    check("vq", 32'(vq), 32'h1);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h1A00);
    check("vlev", 32'(vlev), 32'h0100);
    err_is(32'h0001FF22);
    cmd(omr_pkg::OMR_OP_AUTO, 1'b0, 16'h1);
    cmd(omr_pkg::OMR_OP_AUTO, 1'b1, 16'h0);
    rd(omr_pkg::ADDR_STATUS, 32'h60, 32'h0);
    cmd(omr_pkg::OMR_OP_CURR_RANGE, 1'b1, 16'h4);
    check("iq", 32'(iq), 32'h1);
    err_is(32'h0001FED4);
    cmd(omr_pkg::OMR_OP_FUNC, 1'b0, 16'h1);
    check("imode", 32'(imode), 32'h1);
    check("iq", 32'(iq), 32'h0);
    cmd(omr_pkg::OMR_OP_RANGE, 1'b0, 16'h4);
    check("iq", 32'(iq), 32'h1);
    cmd(omr_pkg::OMR_OP_RESET, 1'b0, 16'h0);
    check("lev", {ilev, vlev}, 32'h0);
    check("imode", 32'(imode), 32'h0);
    rd(omr_pkg::ADDR_STATUS, 32'h60, 32'h60);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h1000);
    cmd(omr_pkg::OMR_OP_TRIG_LEVEL, 1'b0, 16'h0300);
    cmd(omr_pkg::OMR_OP_TRIG_LEVEL, 1'b1, 16'h0200);
    rd(omr_pkg::ADDR_TRIG, 32'hFFFFFFFF, 32'h02000300);
    cmd(omr_pkg::OMR_OP_TRIGGER, 1'b0, 16'h0);
    check("lev", {ilev, vlev}, 32'h02000300);
    cmd(omr_pkg::OMR_OP_TRIG_LEVEL, 1'b0, 16'h7000);
    err_is(32'h0001FF22);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h1000);
    cmd(omr_pkg::OMR_OP_MODE_TRAN, 1'b0, 16'h2);
    rd(omr_pkg::ADDR_STATUS, 32'h3, 32'h2);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h0800);
    check("vlev", 32'(vlev), 32'h0800);
    rd(omr_pkg::ADDR_STATUS, 32'h3, 32'h0);
    repeat (25) @(negedge clk);
    check("vlev", 32'(vlev), 32'h1000);
    cmd(omr_pkg::OMR_OP_MODE_TRAN, 1'b0, 16'h1);
    cmd(omr_pkg::OMR_OP_TRIGGER, 1'b0, 16'h0);
    check("vlev", 32'(vlev), 32'h0300);
    repeat (15) @(negedge clk);
    check("vlev", 32'(vlev), 32'h1000);
    cmd(omr_pkg::OMR_OP_MODE_TRAN, 1'b0, 16'd1001);
    err_is(32'h0001FF22);
    cmd(omr_pkg::OMR_OP_LIST_EDIT, 1'b0, 16'h0);
    rd(omr_pkg::ADDR_ERR, 32'h00010000, 32'h0);
    check("edits", 32'(n_edit), 32'h1);
    cmd(omr_pkg::OMR_OP_MODE_LIST, 1'b0, 16'h0);
    check("lqty", 32'(lqty), 32'h0);
    for (int i = 0; i < 100 && ldone !== 1'b1; i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    check("vlev", 32'(vlev), 32'h0300);
    cmd(omr_pkg::OMR_OP_LEVEL, 1'b0, 16'h1000);
    gap <= 8'h06;
    cmd(omr_pkg::OMR_OP_MODE_LIST, 1'b0, 16'h0);
    rd(omr_pkg::ADDR_STATUS, 32'h3, 32'h1);
    cmd(omr_pkg::OMR_OP_LIST_EDIT, 1'b0, 16'h0);
    err_is(32'h0001FF9C);
    check("edits", 32'(n_edit), 32'h1);
    cmd(omr_pkg::OMR_OP_MODE_FIX, 1'b0, 16'h0);
    check("vlev", 32'(vlev), 32'h1000);
    rd(omr_pkg::ADDR_STATUS, 32'h3, 32'h0);
    give_verdict();
  end
endmodule
